// File: rtl/chrcc_top.sv
// Channel read, chained write and interface command handler
// ==========================================================
`timescale 1ns/100ps
`default_nettype none
module chrcc_top
   import chrcc_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES,
   parameter int QDEPTH = 4
) (
   input wire logic CLK,
   input wire logic RST_B,
   // Command block, one strobe per block
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_B0,
   input wire logic [7:0] CMD_B1,
   input wire logic [7:0] CMD_B2,
   input wire logic [7:0] CMD_B3,
   input wire logic [7:0] CMD_B4,
   input wire logic ASYNC_MODE,
   input wire logic SINGLE_QUEUE,
   // Receive line data and detection events
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_TERM,
   input wire logic RX_ERROR,
   input wire logic RX_RESTART,
   // Transmit side of a chained write
   input wire logic TX_DONE,
   input wire logic TX_ERROR,
   // Parameter table write port
   input wire logic TBL_WE,
   input wire logic TBL_SEL,
   input wire logic [7:0] TBL_ADDR,
   input wire logic [7:0] TBL_WDATA,
   // Host-side input word of the serial bus
   input wire logic HOST_ACK,
   output logic [10:0] HOST_WORD,
   output logic HOST_LAST,
   output logic CHAR_MODE,
   output logic TX_START,
   output logic [3:0] TX_RATE,
   output logic [3:0] RX_RATE,
   output logic SECONDARY_REQUEST_TO_SEND,
   output logic RI_IE,
   output logic DTR_X21,
   output logic INT_CLK,
   output logic FULL_DUPLEX,
   output logic ANALOG_LOOP,
   output logic OUT_EXT_CLK,
   output logic RTS,
   output logic TEST_MODE
);
   typedef enum {S_IDLE, S_DATA, S_REP, S_PDATA} chrcc_state_t;
   chrcc_state_t state;
   // Queue of pending receive requests
   logic [7:0] q_b0 [QDEPTH];
   logic [7:0] q_to [QDEPTH];
   logic [7:0] q_b2 [QDEPTH];
   logic [15:0] q_cnt [QDEPTH];
   logic [$clog2(QDEPTH):0] q_n;
   logic [7:0] tbl [2][TABLE_DEPTH];
   // Chain and current request state
   logic chain_wr_pend, chain_wr_err_seen;
   logic [7:0] chain_err, chain_wb0;
   logic [15:0] remain;
   logic [7:0] elapsed;
   logic first_seen, timer_run;
   logic [7:0] rep [6];
   logic [2:0] rep_idx;
   logic rep_then_pdata;
   logic rep_resume, rep_retire, wr_rep_pend;
   logic [7:0] wr_code;
   logic [7:0] p_addr;
   logic p_sel;
   logic [15:0] p_cnt;
   logic tick;
   // Command decode
   wire [3:0] op = CMD_B0[3:0];
   wire [2:0] md = CMD_B0[6:4];
   wire cmd_read = CMD_VALID && op == OP_READ && md != MOD_PARAM;
   wire cmd_param = CMD_VALID && op == OP_READ && md == MOD_PARAM;
   wire cmd_chain = CMD_VALID && op == OP_CHAIN;
   wire chain_rd = md >= MOD_CHAIN_RD;
   wire cmd_ifwr = CMD_VALID && op == OP_CHIF && md == MOD_IFWR;
   wire cmd_bad = CMD_VALID && ((op == OP_CHIF && md != MOD_IFWR && md != MOD_IFRD)
      || (cmd_chain && !SINGLE_QUEUE));
   wire [15:0] cmd_cnt = {CMD_B3, CMD_B4};
   wire q_push = (cmd_read || (cmd_chain && SINGLE_QUEUE && chain_rd)) && q_n < QDEPTH;
   wire rd_active = q_n != 0 && state == S_DATA;
   wire [2:0] detect_entry = chain_rd ? md - 3'(MOD_CHAIN_RD) : md;
   wire timed_out = timer_run && q_to[0] != 8'h0 && elapsed >= q_to[0];
   wire rx_end = rd_active && (RX_TERM || RX_ERROR || timed_out
      || (RX_VALID && remain == 16'h1 && !CHAR_MODE));
   wire [7:0] end_code = timed_out ? CC_RESTART_TO : (RX_ERROR ? CC_ILLEGAL : CC_OK);
   // A word is cleared on its ack edge, so the next one always follows a gap
   wire word_go = !HOST_WORD[VALID_BIT];
   wire ifwr_ok = CMD_B1[3:0] <= TX_RATE_MAX && CMD_B1[7:4] != RATE_RESERVED;
   wire [7:0] cmd_code = (cmd_ifwr && ifwr_ok) ? CC_OK : CC_ILLEGAL;
   // Oldest entry leaves on the last word of its own completion report
   wire q_pop = state == S_REP && word_go && rep_idx == 3'h5 && rep_retire
      && !rep_resume && !rep_then_pdata;
   wire [$clog2(QDEPTH)-1:0] q_widx = q_n[$clog2(QDEPTH)-1:0]
      - {{($clog2(QDEPTH)-1){1'b0}}, q_pop};
   wire [$clog2(QDEPTH):0] next_q_n = q_n + {{$clog2(QDEPTH){1'b0}}, q_push}
      - {{$clog2(QDEPTH){1'b0}}, q_pop};

   chrcc_tick #(.DIV(TICK_DIV)) u_tick (
      .CLK(CLK),
      .RST_B(RST_B),
      .run(timer_run && !first_seen),
      .tick(tick)
   );

   // Parameter tables written by the local processor side
   always_ff @(posedge CLK) begin
      if (TBL_WE) begin
         tbl[TBL_SEL][TBL_ADDR] <= TBL_WDATA;
      end
   end

   // Interface write: plain control latches
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         {TX_RATE, RX_RATE} <= 8'h0;
         {SECONDARY_REQUEST_TO_SEND, DTR_X21, INT_CLK, FULL_DUPLEX, ANALOG_LOOP} <= 5'h0;
         RI_IE <= 1'b1;
         {OUT_EXT_CLK, RTS, TEST_MODE} <= 3'h0;
      end else if (cmd_ifwr && ifwr_ok) begin
         TX_RATE <= CMD_B1[TX_RATE_LSB +: 4];
         RX_RATE <= CMD_B1[RX_RATE_LSB +: 4];
         SECONDARY_REQUEST_TO_SEND <= CMD_B2[B2_SECONDARY_REQUEST_TO_SEND];
         RI_IE <= !CMD_B2[B2_SECONDARY_REQUEST_TO_SEND];
         DTR_X21 <= CMD_B2[B2_DTR];
         INT_CLK <= CMD_B2[B2_INTCLK];
         FULL_DUPLEX <= CMD_B2[B2_FDX];
         ANALOG_LOOP <= CMD_B2[B2_ALOOP];
         OUT_EXT_CLK <= CMD_B3[B3_OUTEXT];
         RTS <= CMD_B3[B3_RTS];
         TEST_MODE <= CMD_B3[B3_TEST];
      end
   end

   // Main sequencer: queue, data, reports
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state <= S_IDLE;
         q_n <= '0;
         HOST_WORD <= 11'h0;
         HOST_LAST <= 1'b0;
         CHAR_MODE <= 1'b0;
         TX_START <= 1'b0;
         chain_wr_pend <= 1'b0;
         chain_wr_err_seen <= 1'b0;
         chain_err <= 8'h0;
         chain_wb0 <= 8'h0;
         remain <= 16'h0;
         elapsed <= 8'h0;
         first_seen <= 1'b0;
         timer_run <= 1'b0;
         rep_idx <= 3'h0;
         rep_then_pdata <= 1'b0;
         rep_resume <= 1'b0;
         rep_retire <= 1'b0;
         wr_rep_pend <= 1'b0;
         wr_code <= 8'h0;
         p_addr <= 8'h0;
         p_sel <= 1'b0;
         p_cnt <= 16'h0;
         for (int i = 0; i < 6; i++) rep[i] <= 8'h0;
      end else begin
         TX_START <= 1'b0;
         if (HOST_ACK) begin
            HOST_WORD <= 11'h0;
            HOST_LAST <= 1'b0;
         end
         if (tick && elapsed != 8'hff) elapsed <= elapsed + 8'h1;
         // Retire shifts first so a push in the same cycle lands behind it
         if (q_pop) begin
            for (int i = 0; i < QDEPTH - 1; i++) begin
               q_b0[i] <= q_b0[i+1];
               q_to[i] <= q_to[i+1];
               q_b2[i] <= q_b2[i+1];
               q_cnt[i] <= q_cnt[i+1];
            end
         end
         // Enqueue at tail, oldest stays at index 0
         if (q_push) begin
            q_b0[q_widx] <= {CMD_B0[7], 1'b0, detect_entry[1:0], CMD_B0[3:0]};
            q_to[q_widx] <= CMD_B1;
            q_b2[q_widx] <= CMD_B2;
            q_cnt[q_widx] <= cmd_cnt;
         end
         q_n <= next_q_n;
         // Write half is held until its read half arrives
         if (cmd_chain && SINGLE_QUEUE && !chain_rd) begin
            chain_wr_pend <= 1'b1;
            chain_wb0 <= CMD_B0;
         end
         if (cmd_chain && SINGLE_QUEUE && chain_rd && chain_wr_pend) begin
            TX_START <= 1'b1;
            chain_wr_pend <= 1'b0;
         end
         if (TX_ERROR) begin
            chain_wr_err_seen <= 1'b1;
            chain_err <= CC_ILLEGAL;
         end
         case (state)
            S_IDLE: begin
               // Reports started here never retire a queue entry
               rep_resume <= 1'b0;
               rep_retire <= 1'b0;
               if (cmd_bad || cmd_ifwr) begin
                  rep <= '{CMD_B0, 8'h0, 8'h0, 8'h0, 8'h0, cmd_code};
                  rep_then_pdata <= 1'b0;
                  rep_idx <= 3'h0;
                  state <= S_REP;
               end else if (wr_rep_pend) begin
                  rep <= '{chain_wb0, 8'h0, 8'h0, 8'h0, 8'h0, wr_code};
                  wr_rep_pend <= 1'b0;
                  rep_then_pdata <= 1'b0;
                  rep_idx <= 3'h0;
                  state <= S_REP;
               end else if (cmd_param) begin
                  p_addr <= CMD_B1;
                  p_sel <= CMD_B2[SEL_TABLE_BIT];
                  p_cnt <= cmd_cnt;
                  rep <= '{CMD_B0, CMD_B1, CMD_B2, CMD_B3, CMD_B4, CC_OK};
                  rep_then_pdata <= 1'b1;
                  rep_idx <= 3'h0;
                  state <= S_REP;
               end else if (q_n != 0) begin
                  remain <= q_cnt[0];
                  CHAR_MODE <= ASYNC_MODE && q_cnt[0] == CHAR_MODE_COUNT;
                  elapsed <= 8'h0;
                  first_seen <= 1'b0;
                  timer_run <= 1'b1;
                  state <= S_DATA;
               end
            end
            S_DATA: begin
               if (wr_rep_pend) begin
                  // Write-half report cuts in, then the transfer resumes
                  // Limitation: line bytes arriving during the report are not held
                  rep <= '{chain_wb0, 8'h0, 8'h0, 8'h0, 8'h0, wr_code};
                  wr_rep_pend <= 1'b0;
                  rep_resume <= 1'b1;
                  rep_retire <= 1'b0;
                  rep_then_pdata <= 1'b0;
                  rep_idx <= 3'h0;
                  state <= S_REP;
               end else if (chain_wr_err_seen) begin
                  // Read half not run, returned with the write error
                  rep <= '{q_b0[0], 8'h0, 8'h0, 8'h0, 8'h0, chain_err};
                  rep_resume <= 1'b0;
                  rep_retire <= 1'b1;
                  rep_then_pdata <= 1'b0;
                  chain_wr_err_seen <= 1'b0;
                  timer_run <= 1'b0;
                  rep_idx <= 3'h0;
                  state <= S_REP;
               end else if (RX_RESTART && !timed_out && word_go) begin
                  HOST_WORD <= 11'h0;
                  HOST_WORD[RESTART_BIT] <= 1'b1;
                  HOST_WORD[STAT_BIT] <= 1'b1;
                  HOST_WORD[7:0] <= q_b2[0];
                  HOST_WORD[VALID_BIT] <= 1'b1;
                  HOST_LAST <= 1'b1;
                  remain <= q_cnt[0];
                  first_seen <= 1'b0;
               end else if (rx_end && word_go) begin
                  // Last byte goes out before its completion report
                  if (RX_VALID) HOST_WORD <= {1'b1, 2'b00, RX_DATA};
                  rep <= '{q_b0[0], 8'h0, q_b2[0], 8'h0, 8'h0, end_code};
                  rep_resume <= 1'b0;
                  rep_retire <= 1'b1;
                  timer_run <= 1'b0;
                  CHAR_MODE <= 1'b0;
                  rep_then_pdata <= 1'b0;
                  rep_idx <= 3'h0;
                  state <= S_REP;
               end else if (RX_VALID && word_go) begin
                  HOST_WORD <= {1'b1, 2'b00, RX_DATA};
                  first_seen <= 1'b1;
                  if (!CHAR_MODE) remain <= remain - 16'h1;
               end
            end
            S_REP: begin
               if (word_go) begin
                  HOST_WORD <= {3'b101, rep[rep_idx]};
                  HOST_LAST <= rep_idx == 3'h5;
                  rep_idx <= rep_idx + 3'h1;
                  if (rep_idx == 3'h5) begin
                     if (rep_resume) state <= S_DATA;
                     else if (rep_then_pdata) state <= S_PDATA;
                     else state <= S_IDLE;
                  end
               end
            end
            S_PDATA: begin
               if (p_cnt == 16'h0) state <= S_IDLE;
               else if (word_go) begin
                  HOST_WORD <= {1'b1, 2'b00, tbl[p_sel][p_addr]};
                  p_addr <= p_addr + 8'h1;
                  p_cnt <= p_cnt - 16'h1;
               end
            end
            default: state <= S_IDLE;
         endcase
         // Transmit outcome waits for a report slot; a new event beats the clear
         if (TX_DONE || TX_ERROR) begin
            wr_rep_pend <= 1'b1;
            wr_code <= TX_ERROR ? CC_ILLEGAL : CC_OK;
         end
      end
   end
endmodule
`default_nettype wire

// File: shared/chrcc_pkg.sv
// Package of constants for the channel read/chain command handler
package chrcc_pkg;
   // ==========================================================
   // Command codes
   localparam logic [3:0] OP_READ = 4'h4;
   localparam logic [3:0] OP_CHAIN = 4'h5;
   localparam logic [3:0] OP_CHIF = 4'h6;
   localparam logic [2:0] MOD_PARAM = 3'h7;
   localparam logic [2:0] MOD_IFWR = 3'h5;
   localparam logic [2:0] MOD_IFRD = 3'h6;
   localparam logic [2:0] MOD_CHAIN_RD = 3'h4;
   localparam logic [15:0] CHAR_MODE_COUNT = 16'h8000;
   // ==========================================================
   // Report words on the serial bus input side
   localparam int STAT_BIT = 8;
   localparam int RESTART_BIT = 9;
   localparam int VALID_BIT = 10;
   localparam int SEL_TABLE_BIT = 1;
   // ==========================================================
   // Completion codes
   localparam logic [7:0] CC_OK = 8'h00;
   localparam logic [7:0] CC_ILLEGAL = 8'h01;
   localparam logic [7:0] CC_RESTART_TO = 8'h47;
   // ==========================================================
   // Interface-write field positions
   localparam int TX_RATE_LSB = 0;
   localparam int RX_RATE_LSB = 4;
   localparam int B2_SECONDARY_REQUEST_TO_SEND = 1;
   localparam int B2_DTR = 2;
   localparam int B2_INTCLK = 3;
   localparam int B2_FDX = 6;
   localparam int B2_ALOOP = 7;
   localparam int B3_OUTEXT = 1;
   localparam int B3_RTS = 2;
   localparam int B3_TEST = 3;
   localparam logic [3:0] RATE_RESERVED = 4'hf;
   localparam logic [3:0] TX_RATE_MAX = 4'hd;
   // ==========================================================
   // Timing: time-out tick is one unit per millisecond
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam int TABLE_DEPTH = 256;
endpackage

// File: rtl/chrcc_tick.sv
// Tick divider producing one-cycle time-out enables
`timescale 1ns/100ps
`default_nettype none
module chrcc_tick
   import chrcc_pkg::*;
#(
   parameter int DIV = TICK_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic run,
   output logic tick
);
   logic [31:0] cnt;
   // Counter only runs while the timer is armed so stops hold the fraction
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cnt <= 32'h0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (run) begin
            if (cnt >= 32'(DIV - 1)) begin
               cnt <= 32'h0;
               tick <= 1'b1;
            end else begin
               cnt <= cnt + 32'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/chrcc_props.sv
// Port-level assertions of the command handler
`timescale 1ns/100ps
`default_nettype none
module chrcc_props
   import chrcc_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES,
   parameter int QDEPTH = 4
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_B0,
   input wire logic ASYNC_MODE,
   input wire logic HOST_ACK,
   input wire logic [10:0] HOST_WORD,
   input wire logic HOST_LAST,
   input wire logic CHAR_MODE,
   input wire logic TX_START,
   input wire logic [3:0] TX_RATE,
   input wire logic [3:0] RX_RATE,
   input wire logic SECONDARY_REQUEST_TO_SEND,
   input wire logic RI_IE
);
   // ==========
   // Read half seen since the last transmit start
   logic rd_seen;
   wire rd_half = CMD_VALID && CMD_B0[3:0] == OP_CHAIN && CMD_B0[6];
   always_ff @(posedge CLK) begin
      if (!RST_B || TX_START) begin
         rd_seen <= 1'b0;
      end else if (rd_half) begin
         rd_seen <= 1'b1;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // ==========
   // Hand-over of words, reports and control levels
   word_hold_a: assert property (HOST_WORD[10] && !HOST_ACK |=> $stable(HOST_WORD))
      else $error("word moved before ack");
   ack_clear_a: assert property (HOST_ACK && HOST_WORD[10] |=> !HOST_WORD[10])
      else $error("word kept after ack");
   restart_word_a: assert property (HOST_WORD[10] && HOST_WORD[9] |-> HOST_WORD[8])
      else $error("restart word lacks status");
   last_word_a: assert property ($rose(HOST_LAST) |-> HOST_WORD[10])
      else $error("last flag without word");
   chain_order_a: assert property (TX_START |-> rd_seen)
      else $error("transmit before read half");
   char_mode_a: assert property ($rose(CHAR_MODE) |-> ASYNC_MODE)
      else $error("character mode in sync");
   rate_legal_a: assert property (TX_RATE <= TX_RATE_MAX && RX_RATE != RATE_RESERVED)
      else $error("reserved rate applied");
   secondary_request_to_send_ri_a: assert property (SECONDARY_REQUEST_TO_SEND != RI_IE)
      else $error("request and enable agree");
endmodule
bind chrcc_top chrcc_props #(.TICK_DIV(TICK_DIV), .QDEPTH(QDEPTH)) u_props (.CLK(CLK),
   .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_B0(CMD_B0), .ASYNC_MODE(ASYNC_MODE),
   .HOST_ACK(HOST_ACK), .HOST_WORD(HOST_WORD), .HOST_LAST(HOST_LAST), .CHAR_MODE(CHAR_MODE),
   .TX_START(TX_START), .TX_RATE(TX_RATE), .RX_RATE(RX_RATE), .SECONDARY_REQUEST_TO_SEND(SECONDARY_REQUEST_TO_SEND), .RI_IE(RI_IE));
`default_nettype wire

// File: sim/chrcc_host.sv
// Host model that acknowledges and keeps report words
`timescale 1ns/100ps
`default_nettype none
module chrcc_host (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic slow,
   input wire logic [10:0] HOST_WORD,
   input wire logic HOST_LAST,
   output logic HOST_ACK
);
   logic [11:0] got[$];
   logic [10:0] rst_word;
   int wait_n;
   // Take a word on the edge where ack is high; slow mode lags three cycles
   always @(posedge CLK) begin
      if (!RST_B) begin
         HOST_ACK <= 1'b0;
         wait_n <= 0;
      end else if (HOST_ACK) begin
         HOST_ACK <= 1'b0;
         if (HOST_WORD[9]) begin
            got.delete();
            rst_word <= HOST_WORD;
         end else begin
            got.push_back({HOST_LAST, HOST_WORD});
         end
      end else if (HOST_WORD[10] && wait_n == 0) begin
         HOST_ACK <= 1'b1;
      end else if (HOST_WORD[10]) begin
         wait_n <= wait_n - 1;
      end else begin
         wait_n <= slow ? 3 : 0;
      end
   end
endmodule
`default_nettype wire

// File: sim/chrcc_top_test.sv
// Self-checking bench of the command handler
`timescale 1ns/100ps
`default_nettype none
module chrcc_top_test
   import chrcc_pkg::*;
;
   logic CLK = 1'b0, RST_B = 1'b0, CMD_VALID = 1'b0, ASYNC_MODE = 1'b0, SINGLE_QUEUE = 1'b1;
   logic RX_VALID = 1'b0, TBL_WE = 1'b0, TBL_SEL = 1'b0, slow = 1'b0;
   logic [7:0] CMD_B0 = 8'h00, CMD_B1 = 8'h00, CMD_B2 = 8'h00, CMD_B3 = 8'h00, CMD_B4 = 8'h00;
   logic [7:0] RX_DATA = 8'h00, TBL_ADDR = 8'h00, TBL_WDATA = 8'h00, b1, b2, o;
   logic [4:0] evs = 5'h00;
   wire RX_TERM = evs[0], RX_ERROR = evs[1], RX_RESTART = evs[2];
   wire TX_DONE = evs[3], TX_ERROR = evs[4];
   logic HOST_ACK, HOST_LAST, CHAR_MODE, TX_START, SECONDARY_REQUEST_TO_SEND, RI_IE, DTR_X21, INT_CLK;
   logic FULL_DUPLEX, ANALOG_LOOP, OUT_EXT_CLK, RTS, TEST_MODE;
   logic [10:0] HOST_WORD;
   logic [3:0] TX_RATE, RX_RATE;
   wire [16:0] cur_if = {RX_RATE, TX_RATE, SECONDARY_REQUEST_TO_SEND, RI_IE, DTR_X21, INT_CLK, FULL_DUPLEX,
      ANALOG_LOOP, OUT_EXT_CLK, RTS, TEST_MODE};
   logic [16:0] exp_if;
   logic [7:0] tbl[2][256];
   logic [7:0] d[4];
   int fail_count = 0, checked = 0, tx_cnt = 0, k, i, n, c;
   chrcc_top #(.TICK_DIV(4)) DUT (.CLK, .RST_B, .CMD_VALID, .CMD_B0, .CMD_B1, .CMD_B2,
      .CMD_B3, .CMD_B4, .ASYNC_MODE, .SINGLE_QUEUE, .RX_VALID, .RX_DATA, .RX_TERM, .RX_ERROR,
      .RX_RESTART, .TX_DONE, .TX_ERROR, .TBL_WE, .TBL_SEL, .TBL_ADDR, .TBL_WDATA, .HOST_ACK,
      .HOST_WORD, .HOST_LAST, .CHAR_MODE, .TX_START, .TX_RATE, .RX_RATE, .SECONDARY_REQUEST_TO_SEND, .RI_IE,
      .DTR_X21, .INT_CLK, .FULL_DUPLEX, .ANALOG_LOOP, .OUT_EXT_CLK, .RTS, .TEST_MODE);
   chrcc_host h (.CLK, .RST_B, .slow, .HOST_WORD, .HOST_LAST, .HOST_ACK);
   // Clock and a count of transmit starts
   initial forever #5 CLK = ~CLK;
   always @(posedge CLK) tx_cnt <= tx_cnt + int'(TX_START);
   // ==========
   // Expectations and bus tasks
   function automatic logic [16:0] if_bits(input logic [7:0] x1, x2, x3);
      return {x1, x2[1], ~x2[1], x2[2], x2[3], x2[6], x2[7], x3[1], x3[2], x3[3]};
   endfunction
   function automatic logic [7:0] w(input int j);
      return h.got[j][7:0];
   endfunction
   task chk(input string nm, input logic [17:0] e, input logic [17:0] a);
      checked++;
      if (a !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, a);
         fail_count++;
      end
   endtask
   task report_and_stop;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task cmd(input logic [7:0] c0, c1, c2, c3, c4);
      @(posedge CLK);
      {CMD_VALID, CMD_B0, CMD_B1, CMD_B2, CMD_B3, CMD_B4} <= {1'b1, c0, c1, c2, c3, c4};
      slow <= 1'($urandom);
      @(posedge CLK);
      CMD_VALID <= 1'b0;
   endtask
   task rx(input logic [7:0] x);
      @(posedge CLK);
      {RX_VALID, RX_DATA} <= {1'b1, x};
      @(posedge CLK);
      {RX_VALID, RX_DATA} <= {1'b0, ~x};
      // No line buffer in the design: give a slow host time to take the word
      repeat (6) @(posedge CLK);
   endtask
   task ev(input int j);
      @(posedge CLK);
      evs <= 5'h01 << j;
      @(posedge CLK);
      evs <= 5'h00;
   endtask
   // Bounded wait for m words, then a settle gap to catch extra words
   task waitw(input int m);
      for (int t = 0; t < 3000 && h.got.size() < m; t++) @(posedge CLK);
      repeat (20) @(posedge CLK);
      chk("word count", m, h.got.size());
      if (h.got.size() < m) report_and_stop();
   endtask
   task rst;
      RST_B <= 1'b0;
      repeat (20) @(posedge CLK);
      RST_B <= 1'b1;
      exp_if = if_bits(8'h00, 8'h00, 8'h00);
   endtask
   // ==========
   // Main sequence
   initial begin
      void'($urandom(32805));
      rst();
      for (i = 0; i < 512; i++) begin
         @(posedge CLK);
         d[0] = 8'($urandom);
         tbl[i / 256][i % 256] = d[0];
         {TBL_WE, TBL_SEL, TBL_ADDR, TBL_WDATA} <= {1'b1, i[8], i[7:0], d[0]};
      end
      @(posedge CLK);
      TBL_WE <= 1'b0;
      chk("reset outs", exp_if, cur_if);
      // Two queued reads; bytes must go to the older one first
      cmd(8'h04, 8'h00, 8'h00, 8'h00, 8'h02);
      cmd(8'h14, 8'h00, 8'h00, 8'h00, 8'h03);
      for (k = 2; k < 4; k++) begin
         h.got.delete();
         for (i = 0; i < k; i++) begin
            d[i] = 8'($urandom);
            rx(d[i]);
         end
         waitw(k + 6);
         for (i = 0; i < k; i++) chk("read data", d[i], w(i));
         chk("read echo", k == 2 ? 8'h04 : 8'h14, w(k));
         chk("read code", {1'b1, CC_OK}, {h.got[k + 5][11], w(k + 5)});
      end
      // Line error ends a read early
      h.got.delete();
      cmd(8'h04, 8'h00, 8'h00, 8'h00, 8'h08);
      rx(8'h5a);
      ev(1);
      waitw(7);
      chk("error code", 1'b1, w(6) != CC_OK);
      // Restart mid-frame, then the next frame fills the same request
      b2 = 8'($urandom);
      cmd(8'h04, 8'h00, b2, 8'h00, 8'h02);
      rx(8'h33);
      ev(2);
      repeat (20) @(posedge CLK);
      chk("restart word", {3'b111, b2}, h.rst_word);
      rx(8'h11);
      rx(8'h22);
      waitw(8);
      chk("refill", 16'h1122, {w(0), w(1)});
      // Time-out of two units runs out across a restart
      h.got.delete();
      cmd(8'h04, 8'h02, b2, 8'h00, 8'h02);
      ev(2);
      waitw(6);
      chk("timeout code", CC_RESTART_TO, w(5));
      // Parameter reads: report first, then contiguous table bytes
      for (k = 0; k < 2; k++) begin
         h.got.delete();
         o = 8'($urandom % 250);
         n = 1 + $urandom % 4;
         cmd(8'h74, o, {6'h00, k[0], 1'b0}, 8'h00, 8'(n));
         waitw(n + 6);
         chk("param last", 1'b1, h.got[5][11]);
         for (i = 0; i < n; i++) chk("param data", tbl[k][o + i], w(i + 6));
      end
      // Chains at every entry point; the last fails in transmit
      for (k = 0; k < 4; k++) begin
         h.got.delete();
         c = tx_cnt;
         cmd({2'b00, 2'(k), 4'h5}, 8'h00, 8'h00, 8'h00, 8'h01);
         repeat (10) @(posedge CLK);
         chk("tx held", c, tx_cnt);
         cmd({2'b01, 2'(k), 4'h5}, 8'h00, 8'h00, 8'h00, 8'h01);
         repeat (10) @(posedge CLK);
         chk("tx start", c + 1, tx_cnt);
         ev(k == 3 ? 4 : 3);
         if (k < 3) begin
            waitw(6);
            rx(8'h3c);
         end
         waitw(k < 3 ? 13 : 12);
         chk("chain fail", k == 3, w(5) != CC_OK);
         chk("chain pair", w(5), w(k < 3 ? 12 : 11));
      end
      SINGLE_QUEUE <= 1'b0;
      h.got.delete();
      cmd(8'h05, 8'h00, 8'h00, 8'h00, 8'h01);
      waitw(6);
      chk("chain refused", CC_ILLEGAL, w(5));
      // Interface commands; k of 8 is a reserved rate
      for (k = 0; k < 9; k++) if (k != 6) begin
         h.got.delete();
         b1 = k == 8 ? 8'hff : {4'($urandom % 15), 4'($urandom % 14)};
         b2 = 8'($urandom);
         o = 8'($urandom);
         cmd({1'b0, 3'(k == 8 ? 5 : k), 4'h6}, b1, b2, o, 8'h00);
         waitw(6);
         if (k == 5) exp_if = if_bits(b1, b2, o);
         chk("iface code", k == 5 ? CC_OK : CC_ILLEGAL, w(5));
         chk("iface bits", exp_if, cur_if);
      end
      // Count of 8000 in async operation, then a second reset
      ASYNC_MODE <= 1'b1;
      cmd(8'h04, 8'h00, 8'h00, 8'h80, 8'h00);
      repeat (10) @(posedge CLK);
      chk("char mode", 1'b1, CHAR_MODE);
      rst();
      @(posedge CLK);
      chk("reset again", {exp_if, 1'b0}, {cur_if, CHAR_MODE});
      report_and_stop();
   end
endmodule
`default_nettype wire
